/* File: inc/ssc_pkg.sv */
// Constants, types and reset state shared by the serializer side-band block.
// Function
// - Read of a per-lane register with both lanes selected returns lane 1.
// - Write to a per-lane register updates every selected lane's copy.
// - Shared registers are reachable whatever the lane selection bits hold.
// - Second target address enable answers lane 1 address, ignores select bits.
// - Low power-down input returns every control register to its default.
// - Any interconnect fault clears the link detect status bit.
// - Fault kinds are not told apart; one status bit reports them all.
// - Enabled remote interrupt going low drives the interrupt output low.
// - Reading interrupt status clears the pending interrupt, releases output.
// - Remote interrupt mirror follows the remote input level, no clearing.
// - Without a link the remote interrupt mirror is held high.
// - Four-bit pin fields; code 3 forward channel, code 5 back channel.
// - Lane select bits choose which lane's pins the fields configure.
// - Lane 1 pins work only in two-lane mode.
// - Back-channel mode code sets allowed pins: 000/011 four, 010 two, 001 one.
// - Back channel carries a valid flag and four pin bits.
package ssc_pkg;

    localparam logic [7:0] SSC_ADDR_LINK  = 8'h0C;
    localparam logic [7:0] SSC_ADDR_CFG0  = 8'h0D;
    localparam logic [7:0] SSC_ADDR_CFG12 = 8'h0E;
    localparam logic [7:0] SSC_ADDR_CFG3  = 8'h0F;
    localparam logic [7:0] SSC_ADDR_SEL   = 8'h1E;
    localparam logic [7:0] SSC_ADDR_ICTL  = 8'hC6;
    localparam logic [7:0] SSC_ADDR_ISR   = 8'hC7;

    localparam int SSC_SEL_TGT2_BIT = 3;
    localparam int SSC_ICTL_GLB_BIT = 0;
    localparam int SSC_ICTL_REM_BIT = 5;
    localparam int SSC_ISR_REM_BIT  = 5;
    localparam int SSC_ISR_ANY_BIT  = 0;

    localparam logic [7:0] SSC_SEL_RESET  = 8'h01;
    localparam logic [7:0] SSC_CFG_RESET  = 8'h00;
    localparam logic [7:0] SSC_ICTL_RESET = 8'h00;

    localparam logic [3:0] SSC_CODE_FWD = 4'h3;
    localparam logic [3:0] SSC_CODE_BC  = 4'h5;

    localparam logic [2:0] SSC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] SSC_MODE_FAST4  = 3'h3;
    localparam logic [2:0] SSC_MODE_FAST2  = 3'h2;
    localparam logic [2:0] SSC_MODE_FAST1  = 3'h1;

    localparam int SSC_PD_HOLD_MS  = 3;
    localparam int SSC_CLK_KHZ     = 50000;
    localparam int SSC_PD_HOLD_CYC = SSC_PD_HOLD_MS * SSC_CLK_KHZ;

    typedef enum logic [3:0] {
        SSC_IDLE  = 4'h0, SSC_ADDR  = 4'h1, SSC_AACK  = 4'h3,
        SSC_REG   = 4'h2, SSC_RACKW = 4'h6, SSC_WDATA = 4'h7,
        SSC_WACK  = 4'h5, SSC_RDATA = 4'h4, SSC_RACK  = 4'hC
    } ssc_i2c_state_type;

    typedef struct packed {
        logic       valid;
        logic [3:0] gpio;
    } ssc_bc_type;

    typedef struct packed {
        ssc_i2c_state_type st;
        logic [3:0]        cnt;
        logic [7:0]        shift;
        logic [7:0]        ptr;
        logic              rw;
        logic              ack;
        logic [1:0]        tsel;
        logic [1:0][7:0]   cfg_d;
        logic [1:0][7:0]   cfg_e;
        logic [1:0][7:0]   cfg_f;
        logic [1:0]        link_ok;
        logic [7:0]        sel;
        logic [7:0]        ictl;
        logic              pend;
        logic              irq_prev;
        logic              irq_n;
        logic              mirror;
        logic              sda_oe_n;
        logic [1:0][3:0]   gpio_out;
        logic [1:0][3:0]   gpio_oe_n;
        logic [1:0][3:0]   fwd_gpio;
        logic [1:0][3:0]   bc_hold;
        logic              scl1;
        logic              scl2;
        logic              scl_d;
        logic              sda1;
        logic              sda2;
        logic              sda_d;
        logic              pd1;
        logic              pd2;
        logic [1:0][3:0]   gp1;
        logic [1:0][3:0]   gp2;
    } ssc_state_type;

    localparam ssc_state_type SSC_STATE_RESET = '{
        st: SSC_IDLE, sel: SSC_SEL_RESET, ictl: SSC_ICTL_RESET,
        irq_n: 1'b1, mirror: 1'b1, sda_oe_n: 1'b1, irq_prev: 1'b1,
        gpio_oe_n: 8'hFF, scl1: 1'b1, scl2: 1'b1, scl_d: 1'b1,
        sda1: 1'b1, sda2: 1'b1, sda_d: 1'b1, default: '0
    };

endpackage

/* File: src/ssc_sideband.sv */
// Side-band control of the serializer: register port, interrupts, GPIO lanes.
`timescale 1ns/1ps

module ssc_sideband
    import ssc_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR0 = 7'h2A,
    parameter logic [6:0] TARGET_ADDR1 = 7'h2B
) (
    input  wire logic            clk_sys,
    input  wire logic            srst,
    input  wire logic            power_down_n,
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe_n,
    input  wire logic [1:0]      link_up,
    input  wire logic [1:0]      link_fault,
    input  wire logic            two_lane_mode,
    input  wire logic            remote_irq_in_n,
    input  wire logic [2:0]      backchan_sample_mode,
    input  wire ssc_bc_type [1:0] bc_rx,
    input  wire logic [1:0][3:0] gpio_in,
    output logic [1:0][3:0]      gpio_out,
    output logic [1:0][3:0]      gpio_oe_n,
    output logic [1:0][3:0]      fwd_gpio,
    output logic                 irq_out_n,
    output logic                 remote_irq_mirror
);

    ssc_state_type s;
    ssc_state_type next_s;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = s.scl2 & ~s.scl_d;
    assign scl_fall  = ~s.scl2 & s.scl_d;
    assign bus_start = s.scl2 & s.scl_d & s.sda_d & ~s.sda2;
    assign bus_stop  = s.scl2 & s.scl_d & ~s.sda_d & s.sda2;

    always_comb begin
        logic [7:0]      rdata;
        logic            rlane;
        logic            isr_read;
        logic            wr_en;
        logic [7:0]      wdata;
        logic            irq_fall;
        logic            irq_set;
        logic [3:0]      allowed;
        logic [1:0][3:0][3:0] code;
        logic            lane_on;
        ssc_state_type   keep;

        rdata    = 8'h00;
        rlane    = 1'b0;
        isr_read = 1'b0;
        wr_en    = 1'b0;
        wdata    = 8'h00;
        irq_fall = 1'b0;
        irq_set  = 1'b0;
        allowed  = 4'h0;
        code     = '0;
        lane_on  = 1'b0;
        keep     = s;
        next_s   = s;

        // Pins from outside the clock domain pass two flip-flops first.
        next_s.scl1  = scl_in;
        next_s.scl2  = s.scl1;
        next_s.scl_d = s.scl2;
        next_s.sda1  = sda_in;
        next_s.sda2  = s.sda1;
        next_s.sda_d = s.sda2;
        next_s.pd1   = power_down_n;
        next_s.pd2   = s.pd1;
        next_s.gp1   = gpio_in;
        next_s.gp2   = s.gp1;

        // With both lanes selected the lane 1 copy is returned.
        rlane = s.tsel[1];
        case (s.ptr)
            SSC_ADDR_LINK:  rdata = {7'h00, s.link_ok[rlane]};
            SSC_ADDR_CFG0:  rdata = s.cfg_d[rlane];
            SSC_ADDR_CFG12: rdata = s.cfg_e[rlane];
            SSC_ADDR_CFG3:  rdata = s.cfg_f[rlane];
            SSC_ADDR_SEL:   rdata = s.sel;
            SSC_ADDR_ICTL:  rdata = s.ictl;
            SSC_ADDR_ISR: begin
                rdata[SSC_ISR_REM_BIT] = s.pend;
                rdata[SSC_ISR_ANY_BIT] = s.pend;
            end
            default:        rdata = 8'h00;
        endcase

        // Two-wire target: address, register pointer, then data bytes.
        case (s.st)
            SSC_IDLE: begin
                next_s.sda_oe_n = 1'b1;
            end
            SSC_ADDR, SSC_REG, SSC_WDATA: begin
                if (scl_rise) begin
                    next_s.shift = {s.shift[6:0], s.sda2};
                    next_s.cnt   = s.cnt + 4'h1;
                end else if (scl_fall && s.cnt == 4'h8) begin
                    next_s.cnt = 4'h0;
                    if (s.st == SSC_ADDR) begin
                        next_s.rw = s.shift[0];
                        if (s.sel[SSC_SEL_TGT2_BIT] &&
                            s.shift[7:1] == TARGET_ADDR1) begin
                            next_s.tsel     = 2'b10;
                            next_s.st       = SSC_AACK;
                            next_s.sda_oe_n = 1'b0;
                        end else if (s.shift[7:1] == TARGET_ADDR0) begin
                            next_s.tsel = s.sel[SSC_SEL_TGT2_BIT] ?
                                          2'b01 : s.sel[1:0];
                            next_s.st       = SSC_AACK;
                            next_s.sda_oe_n = 1'b0;
                        end else begin
                            next_s.st = SSC_IDLE;
                        end
                    end else if (s.st == SSC_REG) begin
                        next_s.ptr      = s.shift;
                        next_s.st       = SSC_RACKW;
                        next_s.sda_oe_n = 1'b0;
                    end else begin
                        wr_en           = 1'b1;
                        wdata           = s.shift;
                        next_s.st       = SSC_WACK;
                        next_s.sda_oe_n = 1'b0;
                    end
                end
            end
            SSC_AACK, SSC_RACKW, SSC_WACK: begin
                if (scl_rise) begin
                    next_s.cnt = 4'h9;
                end else if (scl_fall && s.cnt == 4'h9) begin
                    next_s.cnt      = 4'h0;
                    next_s.sda_oe_n = 1'b1;
                    if (s.st == SSC_AACK && s.rw) begin
                        // Reading the status register clears the pending flag.
                        isr_read        = (s.ptr == SSC_ADDR_ISR);
                        next_s.shift    = rdata;
                        next_s.ptr      = s.ptr + 8'h01;
                        next_s.sda_oe_n = rdata[7];
                        next_s.st       = SSC_RDATA;
                    end else if (s.st == SSC_AACK) begin
                        next_s.st = SSC_REG;
                    end else begin
                        next_s.st = SSC_WDATA;
                    end
                end
            end
            SSC_RDATA: begin
                if (scl_rise) begin
                    next_s.cnt = s.cnt + 4'h1;
                end else if (scl_fall) begin
                    if (s.cnt == 4'h8) begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.st       = SSC_RACK;
                    end else begin
                        next_s.shift    = {s.shift[6:0], 1'b0};
                        next_s.sda_oe_n = s.shift[6];
                    end
                end
            end
            SSC_RACK: begin
                if (scl_rise) begin
                    next_s.ack = ~s.sda2;
                    next_s.cnt = 4'h9;
                end else if (scl_fall && s.cnt == 4'h9) begin
                    next_s.cnt = 4'h0;
                    if (s.ack) begin
                        isr_read        = (s.ptr == SSC_ADDR_ISR);
                        next_s.shift    = rdata;
                        next_s.ptr      = s.ptr + 8'h01;
                        next_s.sda_oe_n = rdata[7];
                        next_s.st       = SSC_RDATA;
                    end else begin
                        next_s.st = SSC_IDLE;
                    end
                end
            end
            default: begin
                next_s.st       = SSC_IDLE;
                next_s.sda_oe_n = 1'b1;
            end
        endcase

        // A start, repeated or not, always wins over the byte in flight.
        if (bus_start) begin
            next_s.st       = SSC_ADDR;
            next_s.cnt      = 4'h0;
            next_s.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            next_s.st       = SSC_IDLE;
            next_s.sda_oe_n = 1'b1;
        end

        // Register writes; the pointer advances so bursts fill in order.
        if (wr_en) begin
            next_s.ptr = s.ptr + 8'h01;
            for (int i = 0; i < 2; i++) begin
                if (s.tsel[i]) begin
                    case (s.ptr)
                        SSC_ADDR_CFG0:  next_s.cfg_d[i] = wdata;
                        SSC_ADDR_CFG12: next_s.cfg_e[i] = wdata;
                        SSC_ADDR_CFG3:  next_s.cfg_f[i] = wdata;
                        default:        next_s.cfg_d[i] = s.cfg_d[i];
                    endcase
                end
            end
            case (s.ptr)
                SSC_ADDR_SEL:  next_s.sel  = wdata;
                SSC_ADDR_ICTL: next_s.ictl = wdata;
                default:       next_s.sel  = s.sel;
            endcase
        end

        // Any fault kind simply drops the single detect bit of its lane.
        next_s.link_ok = link_up & ~link_fault;

        // Only falling edges raise a pending flag; a set beats a status read.
        next_s.irq_prev = remote_irq_in_n;
        irq_fall = s.irq_prev & ~remote_irq_in_n;
        irq_set  = irq_fall & (|link_up) & s.ictl[SSC_ICTL_REM_BIT] &
                   s.ictl[SSC_ICTL_GLB_BIT];
        next_s.pend  = irq_set | (s.pend & ~isr_read);
        next_s.irq_n = ~(next_s.pend &
                         next_s.ictl[SSC_ICTL_GLB_BIT]);

        next_s.mirror = (|link_up) ? remote_irq_in_n : 1'b1;

        case (backchan_sample_mode)
            SSC_MODE_NORMAL, SSC_MODE_FAST4: allowed = 4'hF;
            SSC_MODE_FAST2:                  allowed = 4'h3;
            SSC_MODE_FAST1:                  allowed = 4'h1;
            default:                         allowed = 4'h0;
        endcase

        for (int i = 0; i < 2; i++) begin
            code[i][0] = s.cfg_d[i][3:0];
            code[i][1] = s.cfg_e[i][3:0];
            code[i][2] = s.cfg_e[i][7:4];
            code[i][3] = s.cfg_f[i][3:0];
            lane_on    = (i == 0) || two_lane_mode;
            for (int p = 0; p < 4; p++) begin
                if (bc_rx[i].valid && allowed[p]) begin
                    next_s.bc_hold[i][p] = bc_rx[i].gpio[p];
                end
                next_s.fwd_gpio[i][p] = lane_on &&
                    code[i][p] == SSC_CODE_FWD && s.gp2[i][p];
                if (lane_on && code[i][p] == SSC_CODE_BC) begin
                    next_s.gpio_oe_n[i][p] = 1'b0;
                    next_s.gpio_out[i][p]  = s.bc_hold[i][p];
                end else begin
                    next_s.gpio_oe_n[i][p] = 1'b1;
                    next_s.gpio_out[i][p]  = 1'b0;
                end
            end
        end

        // Power-down clears all control state but keeps the synchronisers.
        if (!s.pd2) begin
            keep         = next_s;
            next_s       = SSC_STATE_RESET;
            next_s.scl1  = keep.scl1;
            next_s.scl2  = keep.scl2;
            next_s.scl_d = keep.scl_d;
            next_s.sda1  = keep.sda1;
            next_s.sda2  = keep.sda2;
            next_s.sda_d = keep.sda_d;
            next_s.pd1   = keep.pd1;
            next_s.pd2   = keep.pd2;
            next_s.gp1   = keep.gp1;
            next_s.gp2   = keep.gp2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= SSC_STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out           = 1'b0;
    assign sda_oe_n          = s.sda_oe_n;
    assign gpio_out          = s.gpio_out;
    assign gpio_oe_n         = s.gpio_oe_n;
    assign fwd_gpio          = s.fwd_gpio;
    assign irq_out_n         = s.irq_n;
    assign remote_irq_mirror = s.mirror;

endmodule

/* File: sim/ssc_sideband_asserts.sv */
// Port-level checker for the serializer side-band block.
`timescale 1ns/1ps

module ssc_sideband_asserts
    import ssc_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             srst,
    input wire logic             power_down_n,
    input wire logic [1:0]       link_up,
    input wire logic             two_lane_mode,
    input wire logic             remote_irq_in_n,
    input wire logic [2:0]       backchan_sample_mode,
    input wire ssc_bc_type [1:0] bc_rx,
    input wire logic [1:0][3:0]  gpio_out,
    input wire logic [1:0][3:0]  gpio_oe_n,
    input wire logic [1:0][3:0]  fwd_gpio,
    input wire logic             irq_out_n,
    input wire logic             remote_irq_mirror
);
    logic [2:0] pd_hi;
    logic [2:0] pd_lo;

    // Power-down passes two sync stages, so its effect lags the pin.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pd_hi <= 3'h0;
            pd_lo <= 3'h0;
        end else begin
            pd_hi <= !power_down_n ? 3'h0 : pd_hi + {2'h0, pd_hi != 3'h7};
            pd_lo <= power_down_n ? 3'h0 : pd_lo + {2'h0, pd_lo != 3'h7};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_irq_cause: assert property (
        $fell(irq_out_n) |->
        !$past(remote_irq_in_n) || !$past(remote_irq_in_n, 2))
        else $error("irq output fell without a remote request");
    a_after_reset: assert property (
        $fell(srst) |-> irq_out_n && remote_irq_mirror
        && gpio_oe_n == 8'hFF)
        else $error("outputs not idle after reset");
    a_pd_defaults: assert property (
        pd_lo == 3'h7 |-> irq_out_n && remote_irq_mirror
        && gpio_oe_n == 8'hFF && fwd_gpio == 8'h00)
        else $error("outputs not idle in power down");
    a_mirror_follow: assert property (
        pd_hi == 3'h7 && link_up != 2'h0 |=>
        remote_irq_mirror == $past(remote_irq_in_n))
        else $error("mirror does not follow remote input");
    a_mirror_nolink: assert property (
        pd_hi == 3'h7 && link_up == 2'h0 |=> remote_irq_mirror)
        else $error("mirror low without link");
    a_lane1_gate: assert property (
        !two_lane_mode && !$past(two_lane_mode)
        && !$past(two_lane_mode, 2) |-> gpio_oe_n[1] == 4'hF)
        else $error("lane 1 pin driven in one-lane mode");
    a_bc_pin0: assert property (
        pd_hi == 3'h7 && bc_rx[0].valid && !backchan_sample_mode[2]
        |-> ##3 (gpio_oe_n[0][0]
        || gpio_out[0][0] == $past(bc_rx[0].gpio[0], 3)))
        else $error("pin 0 misses back channel sample");
    a_bc_pins4: assert property (
        pd_hi == 3'h7 && bc_rx[0].valid
        && (backchan_sample_mode == SSC_MODE_NORMAL
        || backchan_sample_mode == SSC_MODE_FAST4) |-> ##3
        ((gpio_out[0] ^ $past(bc_rx[0].gpio, 3)) & ~gpio_oe_n[0]) == 4'h0)
        else $error("four-pin mode misses a sample");
    a_fast1_hold: assert property (
        bc_rx[0].valid && backchan_sample_mode == SSC_MODE_FAST1
        |-> ##1 $stable(gpio_out[0][3:1]) [*3])
        else $error("single-pin mode changed other pins");

    c_irq: cover property ($fell(irq_out_n));
    c_fast1: cover property (
        bc_rx[0].valid && backchan_sample_mode == SSC_MODE_FAST1);
    c_pd: cover property (pd_lo == 3'h7);
endmodule

bind ssc_sideband ssc_sideband_asserts u_ssc_sideband_asserts (
    .clk_sys(clk_sys), .srst(srst), .power_down_n(power_down_n),
    .link_up(link_up), .two_lane_mode(two_lane_mode),
    .remote_irq_in_n(remote_irq_in_n),
    .backchan_sample_mode(backchan_sample_mode), .bc_rx(bc_rx),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .fwd_gpio(fwd_gpio),
    .irq_out_n(irq_out_n), .remote_irq_mirror(remote_irq_mirror)
);

/* File: sim/ssc_remote_des.sv */
// Behavioural remote deserializer on the link side of the block.
`timescale 1ns/1ps

module ssc_remote_des
    import ssc_pkg::*;
(
    input  wire logic        clk_sys,
    output logic [1:0]       link_up,
    output logic [1:0]       link_fault,
    output logic             two_lane_mode,
    output logic             remote_irq_in_n,
    output logic [2:0]       backchan_sample_mode,
    output ssc_bc_type [1:0] bc_rx
);
    initial begin
        link_up = 2'h0;
        link_fault = 2'h0;
        two_lane_mode = 1'b0;
        remote_irq_in_n = 1'b1;
        backchan_sample_mode = SSC_MODE_NORMAL;
        bc_rx = '0;
    end

    task automatic set_link(input logic [1:0] up, input logic [1:0] flt,
                            input logic two);
        @(posedge clk_sys);
        link_up <= up;
        link_fault <= flt;
        two_lane_mode <= two;
    endtask

    task automatic set_irq(input logic lvl);
        @(posedge clk_sys);
        remote_irq_in_n <= lvl;
    endtask

    task automatic set_mode(input logic [2:0] m);
        @(posedge clk_sys);
        backchan_sample_mode <= m;
    endtask

    // Between samples the data field shows the inverse, never stale data.
    task automatic sample(input int l, input logic [3:0] g);
        @(posedge clk_sys);
        bc_rx[l] <= '{valid: 1'b1, gpio: g};
        @(posedge clk_sys);
        bc_rx[l] <= '{valid: 1'b0, gpio: ~g};
    endtask
endmodule

/* File: sim/ssc_sideband_bench.sv */
// Self-checking bench for the serializer side-band block.
`timescale 1ns/1ps

module ssc_sideband_bench
    import ssc_pkg::*;
;
    localparam logic [6:0] ADDR0 = 7'h2A;
    localparam logic [6:0] ADDR1 = 7'h2B;
    logic             clk_sys = 1'b0;
    logic             srst = 1'b1;
    logic             power_down_n = 1'b1;
    logic             scl = 1'b1;
    logic             sda_drv = 1'b1;
    logic [1:0][3:0]  gpio_in = 8'h00;
    logic             sda_out, sda_oe_n, irq_out_n, remote_irq_mirror;
    logic             two_lane_mode, remote_irq_in_n;
    logic [1:0]       link_up, link_fault;
    logic [2:0]       backchan_sample_mode;
    ssc_bc_type [1:0] bc_rx;
    logic [1:0][3:0]  gpio_out, gpio_oe_n, fwd_gpio;
    logic             sda_wire;
    logic [7:0]       q;
    logic             ack;
    int               n_fail = 0;
    int               tests_run = 0;

    // Open-drain data line with the host's pull-up.
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);
    always #10 clk_sys = ~clk_sys;

    ssc_sideband #(.TARGET_ADDR0(ADDR0), .TARGET_ADDR1(ADDR1)) u_ssc_sideband (
        .clk_sys(clk_sys), .srst(srst), .power_down_n(power_down_n),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .link_up(link_up), .link_fault(link_fault),
        .two_lane_mode(two_lane_mode), .remote_irq_in_n(remote_irq_in_n),
        .backchan_sample_mode(backchan_sample_mode), .bc_rx(bc_rx),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .fwd_gpio(fwd_gpio), .irq_out_n(irq_out_n),
        .remote_irq_mirror(remote_irq_mirror));
    ssc_remote_des u_ssc_remote_des (
        .clk_sys(clk_sys), .link_up(link_up), .link_fault(link_fault),
        .two_lane_mode(two_lane_mode), .remote_irq_in_n(remote_irq_in_n),
        .backchan_sample_mode(backchan_sample_mode), .bc_rx(bc_rx));

    task automatic summarize;
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Six clocks per bus phase keeps well clear of the sync stages.
    task automatic hp;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic go_start;
        sda_drv <= 1'b1;
        hp;
        scl <= 1'b1;
        hp;
        sda_drv <= 1'b0;
        hp;
        scl <= 1'b0;
        hp;
    endtask

    task automatic go_stop;
        sda_drv <= 1'b0;
        hp;
        scl <= 1'b1;
        hp;
        sda_drv <= 1'b1;
        hp;
    endtask

    task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                        output logic a);
        logic [8:0] w;
        for (int i = 8; i >= 0; i--) begin
            sda_drv <= (i == 0) ? 1'b1 : d[i-1];
            hp;
            scl <= 1'b1;
            hp;
            w[i] = sda_wire;
            scl <= 1'b0;
            hp;
        end
        r = w[8:1];
        a = !w[0];
    endtask

    task automatic wr(input logic [6:0] ad, input logic [7:0] rg,
                      input logic [7:0] dt);
        logic [7:0] r;
        logic a1, a2, a3;
        go_start;
        xfer({ad, 1'b0}, r, a1);
        xfer(rg, r, a2);
        xfer(dt, r, a3);
        go_stop;
        chk("write ack", 8'h01, {7'h0, a1 & a2 & a3});
    endtask

    task automatic rd(input logic [6:0] ad, input logic [7:0] rg);
        logic [7:0] r;
        logic a;
        go_start;
        xfer({ad, 1'b0}, r, ack);
        xfer(rg, r, a);
        go_start;
        xfer({ad, 1'b1}, r, a);
        xfer(8'hFF, q, a);
        go_stop;
    endtask

    task automatic rchk(input string nm, input logic [6:0] ad,
                        input logic [7:0] rg, input logic [7:0] e);
        rd(ad, rg);
        chk(nm, e, q);
    endtask

    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq_out_n !== e && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq_out_n", {7'h0, e}, {7'h0, irq_out_n});
        if (irq_out_n !== e) summarize;
    endtask

    task automatic t_lanes;
        chk("irq idle", 8'h01, {7'h0, irq_out_n});
        chk("mirror", 8'h01, {7'h0, remote_irq_mirror});
        rchk("sel", ADDR0, SSC_ADDR_SEL, SSC_SEL_RESET);
        wr(ADDR0, SSC_ADDR_SEL, 8'h03);
        wr(ADDR0, SSC_ADDR_CFG0, 8'h35);
        wr(ADDR0, SSC_ADDR_SEL, 8'h02);
        rchk("lane1", ADDR0, SSC_ADDR_CFG0, 8'h35);
        wr(ADDR0, SSC_ADDR_CFG0, 8'h53);
        wr(ADDR0, SSC_ADDR_ICTL, 8'h21);
        rchk("shared", ADDR0, SSC_ADDR_ICTL, 8'h21);
        wr(ADDR0, SSC_ADDR_SEL, 8'h03);
        rchk("both", ADDR0, SSC_ADDR_CFG0, 8'h53);
        rchk("refused", ADDR1, SSC_ADDR_CFG0, 8'hFF);
        wr(ADDR0, SSC_ADDR_SEL, 8'h0A);
        rchk("addr1", ADDR1, SSC_ADDR_CFG0, 8'h53);
        rchk("addr0", ADDR0, SSC_ADDR_CFG0, 8'h35);
        wr(ADDR0, SSC_ADDR_SEL, 8'h01);
    endtask

    task automatic t_link_irq;
        u_ssc_remote_des.set_link(2'h3, 2'h1, 1'b0);
        rd(ADDR0, SSC_ADDR_LINK);
        chk("lane0 link", 8'h00, {7'h0, q[0]});
        wr(ADDR0, SSC_ADDR_SEL, 8'h02);
        rd(ADDR0, SSC_ADDR_LINK);
        chk("lane1 link", 8'h01, {7'h0, q[0]});
        u_ssc_remote_des.set_irq(1'b0);
        wait_irq(1'b0);
        chk("mirror", 8'h00, {7'h0, remote_irq_mirror});
        rchk("isr", ADDR0, SSC_ADDR_ISR, 8'h21);
        wait_irq(1'b1);
        chk("mirror", 8'h00, {7'h0, remote_irq_mirror});
        u_ssc_remote_des.set_irq(1'b1);
        u_ssc_remote_des.set_irq(1'b0);
        wait_irq(1'b0);
        rd(ADDR0, SSC_ADDR_ISR);
        u_ssc_remote_des.set_irq(1'b1);
    endtask

    task automatic t_gpio;
        logic [2:0] md [4] = '{3'h0, 3'h2, 3'h1, 3'h3};
        logic [3:0] sm [4] = '{4'hE, 4'h1, 4'h0, 4'h3};
        logic [3:0] ex [4] = '{4'hE, 4'hD, 4'hC, 4'h3};
        wr(ADDR0, SSC_ADDR_CFG0, 8'h05);
        chk("lane1 off", 8'h0F, {4'h0, gpio_oe_n[1]});
        u_ssc_remote_des.set_link(2'h3, 2'h0, 1'b1);
        repeat (3) @(posedge clk_sys);
        chk("lane1 on", 8'h0E, {4'h0, gpio_oe_n[1]});
        wr(ADDR0, SSC_ADDR_SEL, 8'h01);
        wr(ADDR0, SSC_ADDR_CFG0, 8'h03);
        wr(ADDR0, SSC_ADDR_CFG12, 8'h55);
        wr(ADDR0, SSC_ADDR_CFG3, 8'h05);
        gpio_in <= 8'h01;
        repeat (5) @(posedge clk_sys);
        chk("fwd", 8'h01, {4'h0, fwd_gpio[0]});
        chk("bc oe", 8'h01, {4'h0, gpio_oe_n[0]});
        wr(ADDR0, SSC_ADDR_CFG0, 8'h05);
        for (int i = 0; i < 4; i++) begin
            u_ssc_remote_des.set_mode(md[i]);
            u_ssc_remote_des.sample(0, sm[i]);
            repeat (3) @(posedge clk_sys);
            chk("bc pins", {4'h0, ex[i]}, {4'h0, gpio_out[0]});
        end
    endtask

    task automatic t_power_down;
        wr(ADDR0, SSC_ADDR_SEL, 8'h03);
        // The block needs only its sync edges; a 3 ms hold would dwarf the run.
        power_down_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("pd oe", 8'hFF, gpio_oe_n);
        power_down_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rchk("pd sel", ADDR0, SSC_ADDR_SEL, SSC_SEL_RESET);
        rchk("pd cfg", ADDR0, SSC_ADDR_CFG0, SSC_CFG_RESET);
        rchk("pd ictl", ADDR0, SSC_ADDR_ICTL, SSC_ICTL_RESET);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        t_lanes;
        t_link_irq;
        t_gpio;
        t_power_down;
        summarize;
    end
endmodule
